// File: pkg/tmc_defines.svh
// Register map, field positions, reset values and timing counts of the timer/counter
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

`define TMC_ADDR_W        8
`define TMC_OFF_CTRL      8'h00
`define TMC_OFF_LOW       8'h04
`define TMC_OFF_HIGH      8'h08
`define TMC_OFF_STAT      8'h0C
`define TMC_OFF_MASK      8'h10

`define TMC_BIT_ENABLE    0
`define TMC_BIT_CSEL      1
`define TMC_BIT_SYNCBYP   2
`define TMC_BIT_OSCEN     3
`define TMC_PS_LSB        4
`define TMC_PS_MSB        5
`define TMC_BIT_CRYSTAL   6
`define TMC_BIT_WIDE      7
`define TMC_BIT_OVF       0

`define TMC_SYNC_N        5
`define TMC_SYNC_EXT      0
`define TMC_SYNC_XTAL     1
`define TMC_SYNC_SYS      2
`define TMC_SYNC_LVL_LSB  3
`define TMC_SYNC_LVL_MSB  4

`define TMC_CTRL_RST      8'h00
`define TMC_COUNT_RST     16'h0000
`define TMC_COUNT_MAX     16'hFFFF
`define TMC_BYTE_RST      8'h00
`define TMC_INSTR_LAST    2'h3
`define TMC_PS_CNT_RST    3'h0
`define TMC_PS_ALL        3'h7
`define TMC_PINS_INPUT    2'h3
`define TMC_PINS_ZERO     2'h0
`define TMC_RD_PAD        24'h000000
`define TMC_FLAG_PAD      7'h00
`define TMC_HTRANS_NONSEQ 2'h2

`endif

// File: pkg/tmc_pkg.sv
// Types shared by the timer/counter design files
`default_nettype none
package tmc_pkg;
    typedef enum logic [1:0] {
        TMC_DP_IDLE  = 2'b00,
        TMC_DP_WRITE = 2'b01,
        TMC_DP_RWAIT = 2'b10,
        TMC_DP_RDONE = 2'b11
    } tmc_dphase_t;
endpackage : tmc_pkg
`default_nettype wire

// File: rtl/tmc_prescaler.sv
// Divide-by-1/2/4/8 prescaler for the count tick
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"
module tmc_prescaler
    import tmc_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_clk_en,
    input  wire logic       i_tick,
    input  wire logic       i_clear,
    input  wire logic [1:0] i_sel,
    output logic            o_tick
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] shifted;
    logic [2:0] div_mask;

    assign shifted  = `TMC_PS_ALL << i_sel;
    assign div_mask = ~shifted; // RQ3
    assign o_tick   = i_tick && ((cnt_reg & div_mask) == div_mask); // RQ3
    // Clear beats a tick so the first full period starts right after the write
    assign cnt_next = i_clear ? `TMC_PS_CNT_RST : (i_tick ? cnt_reg + 3'h1 : cnt_reg); // RQ9

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= `TMC_PS_CNT_RST;
        end else if (i_clk_en) begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : tmc_prescaler
`default_nettype wire

// File: rtl/tmc_timer.sv
// Sixteen-bit timer/counter with AHB-Lite register slave
// How it works
// RQ1 - Counting happens only while the enable bit is set; otherwise count holds.
// RQ2 - Source select 0 counts instruction cycles; 1 counts external or crystal rising edges.
// RQ3 - Two-bit prescale field divides the count clock by 1, 2, 4 or 8.
// RQ4 - Sync bypass bit chooses synchronised or raw external counting; ignored internally. Counting here always uses the synchronised path.
// RQ5 - Wide access bit picks buffered 16-bit access or two independent bytes.
// RQ6 - Wide mode: reading the low byte copies live high byte into buffer.
// RQ7 - Wide mode: high writes hit buffer; low write loads all sixteen bits.
// RQ8 - Wide mode: high address always reaches the buffer, never the live byte.
// RQ9 - Low byte writes clear the prescaler; high address writes leave it alone.
// RQ10 - Oscillator enable bit runs the crystal oscillator; off when clear.
// RQ11 - Read-only status bit shows system clock comes from this crystal.
// RQ12 - While enabled both clock pins are inputs, direction ignored, reads give zero.
// RQ13 - Enabled oscillator keeps running in every power-managed mode.
// RQ14 - Control register resets to all zeros.
// RQ15 - Software waits a start-up delay after enabling the oscillator.
// RQ16 - Count wraps FFFF to 0000 and latches the overflow flag; enable gates interrupt.
// RQ17 - Special trigger clears count in timer or sync mode, no flag; writes win.
// RQ18 - Sync counter mode passes external clock through two flops and edge detect.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"
module tmc_timer
    import tmc_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_clk_en,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_external_count_pin,
    input  wire logic        i_crystal_osc_clk,
    input  wire logic        i_sysclk_on_crystal,
    input  wire logic        i_special_trigger,
    input  wire logic [1:0]  i_port_direction_bits,
    input  wire logic [1:0]  i_pin_levels,
    output logic [1:0]       o_pin_direction,
    output logic [1:0]       o_pin_read,
    output logic             o_crystal_osc_enable,
    output logic             o_irq
);
    // Async inputs: external pin, crystal output, clock status, pin levels
    localparam int NSYNC = `TMC_SYNC_N;

    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync2_reg;
    logic [1:0]       pin_levels_sync;
    logic             ext_prev_reg;

    tmc_dphase_t      dp_reg;
    tmc_dphase_t      dp_next;
    logic [7:0]       dp_addr_reg;
    logic [31:0]      hrdata_reg;

    logic             count_enable;
    logic             clock_source_select;
    logic             sync_bypass;
    logic             crystal_osc_enable;
    logic [1:0]       prescale_select;
    logic             wide_access_mode;
    logic [15:0]      count_reg;
    logic [15:0]      count_next;
    logic [7:0]       high_buf_reg;
    logic [7:0]       high_buf_next;
    logic             overflow_flag_reg;
    logic             overflow_flag_next;
    logic             overflow_irq_enable;
    logic [1:0]       instr_div_reg;

    logic             addr_phase;
    logic             wr_act;
    logic             rd_cap;
    logic             sel_ctrl;
    logic             sel_low;
    logic             sel_high;
    logic             sel_stat;
    logic             sel_mask;
    logic             wr_ctrl;
    logic             wr_low;
    logic             wr_high;
    logic             wr_mask;
    logic             rd_low;
    logic             rd_stat;
    logic [7:0]       wdata;
    logic [7:0]       ctrl_view;
    logic [7:0]       rd_val;
    logic             instr_tick;
    logic             ext_level;
    logic             ext_edge;
    logic             src_tick;
    logic             ps_tick;
    logic             inc;
    logic             trig_allowed;
    logic             wrap;

    // Two flops before any logic reads a pin level
    assign async_in = {i_pin_levels, i_sysclk_on_crystal,
                       i_crystal_osc_clk, i_external_count_pin};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
            logic stage1_reg;
            logic stage2_reg;

            always_ff @(posedge i_ref_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                end else if (i_clk_en) begin
                    stage1_reg <= async_in[g];
                    stage2_reg <= stage1_reg;
                end
            end

            assign sync2_reg[g] = stage2_reg;
        end
    endgenerate

    assign pin_levels_sync = sync2_reg[`TMC_SYNC_LVL_MSB:`TMC_SYNC_LVL_LSB];

    // Bus decode
    assign addr_phase = i_hsel && i_htrans[1] && i_hready;
    assign wr_act     = (dp_reg == TMC_DP_WRITE) && i_clk_en;
    assign rd_cap     = (dp_reg == TMC_DP_RWAIT) && i_clk_en;
    assign sel_ctrl   = dp_addr_reg == `TMC_OFF_CTRL;
    assign sel_low    = dp_addr_reg == `TMC_OFF_LOW;
    assign sel_high   = dp_addr_reg == `TMC_OFF_HIGH;
    assign sel_stat   = dp_addr_reg == `TMC_OFF_STAT;
    assign sel_mask   = dp_addr_reg == `TMC_OFF_MASK;
    assign wr_ctrl    = wr_act && sel_ctrl;
    assign wr_low     = wr_act && sel_low;
    assign wr_high    = wr_act && sel_high;
    assign wr_mask    = wr_act && sel_mask;
    assign rd_low     = rd_cap && sel_low;
    assign rd_stat    = rd_cap && sel_stat;
    assign wdata      = i_hwdata[7:0];

    // Reads wait one cycle so a write just before is always seen
    always_comb begin
        dp_next = TMC_DP_IDLE;
        unique case (dp_reg)
            TMC_DP_RWAIT: begin
                dp_next = TMC_DP_RDONE;
            end
            TMC_DP_IDLE,
            TMC_DP_WRITE,
            TMC_DP_RDONE: begin
                if (addr_phase) begin
                    dp_next = i_hwrite ? TMC_DP_WRITE : TMC_DP_RWAIT;
                end
            end
        endcase
    end

    // A frozen data phase holds hreadyout low so no transfer is lost
    assign o_hreadyout = !(dp_reg == TMC_DP_RWAIT) && (i_clk_en || dp_reg == TMC_DP_IDLE);
    assign o_hresp     = 1'b0;
    assign o_hrdata    = hrdata_reg;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dp_reg      <= TMC_DP_IDLE;
            dp_addr_reg <= `TMC_BYTE_RST;
        end else if (i_clk_en) begin
            dp_reg <= dp_next;
            if (addr_phase) begin
                dp_addr_reg <= i_haddr[7:0];
            end
        end
    end

    // Read view; bit 6 is live status, never stored
    assign ctrl_view = {wide_access_mode, sync2_reg[`TMC_SYNC_SYS], prescale_select,
                        crystal_osc_enable, sync_bypass, clock_source_select,
                        count_enable}; // RQ11
    assign rd_val = sel_ctrl ? ctrl_view
                  : sel_low  ? count_reg[7:0]
                  : sel_high ? (wide_access_mode ? high_buf_reg : count_reg[15:8]) // RQ8
                  : sel_stat ? {`TMC_FLAG_PAD, overflow_flag_reg}
                  : sel_mask ? {`TMC_FLAG_PAD, overflow_irq_enable}
                  : `TMC_BYTE_RST;

    // Captured once in the wait cycle; stands until the next read
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hrdata_reg <= {`TMC_RD_PAD, `TMC_BYTE_RST};
        end else if (rd_cap) begin
            hrdata_reg <= {`TMC_RD_PAD, rd_val};
        end
    end

    // Control register; the mask has its own block
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_enable        <= 1'b0; // RQ14
            clock_source_select <= 1'b0;
            sync_bypass         <= 1'b0;
            crystal_osc_enable  <= 1'b0;
            prescale_select     <= `TMC_PINS_ZERO;
            wide_access_mode    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                count_enable        <= wdata[`TMC_BIT_ENABLE];
                clock_source_select <= wdata[`TMC_BIT_CSEL];
                sync_bypass         <= wdata[`TMC_BIT_SYNCBYP];
                crystal_osc_enable  <= wdata[`TMC_BIT_OSCEN];
                prescale_select     <= wdata[`TMC_PS_MSB:`TMC_PS_LSB];
                wide_access_mode    <= wdata[`TMC_BIT_WIDE]; // RQ5
            end
        end
    end

    // Mask kept apart so a control write never disturbs it
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            overflow_irq_enable <= 1'b0;
        end else if (wr_mask) begin
            overflow_irq_enable <= wdata[`TMC_BIT_OVF]; // RQ16
        end
    end

    // Not gated by any power mode, so the crystal keeps running in sleep
    assign o_crystal_osc_enable = crystal_osc_enable; // RQ10 RQ13

    // Pins become inputs and read as zero while counting is enabled
    assign o_pin_direction = count_enable ? `TMC_PINS_INPUT : i_port_direction_bits; // RQ12
    // Readback passes the synchroniser like every other pin, so it lags two clocks
    assign o_pin_read      = count_enable ? `TMC_PINS_ZERO : pin_levels_sync; // RQ12

    // Instruction cycle is four reference clocks
    assign instr_tick = instr_div_reg == `TMC_INSTR_LAST;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            instr_div_reg <= `TMC_PINS_ZERO;
            ext_prev_reg  <= 1'b0;
        end else if (i_clk_en) begin
            instr_div_reg <= instr_div_reg + 2'h1;
            ext_prev_reg  <= ext_level;
        end
    end

    // Crystal output replaces the pin while the oscillator is on
    assign ext_level = crystal_osc_enable ? sync2_reg[`TMC_SYNC_XTAL] : sync2_reg[`TMC_SYNC_EXT]; // RQ2
    assign ext_edge  = ext_level && !ext_prev_reg; // RQ18
    // Single clock here: bypass mode shares the synchronised path
    assign src_tick  = clock_source_select ? ext_edge : instr_tick; // RQ2 RQ4

    tmc_prescaler u_prescaler (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_clk_en  (i_clk_en),
        .i_tick    (src_tick),
        .i_clear   (wr_low),
        .i_sel     (prescale_select),
        .o_tick    (ps_tick)
    );

    assign inc          = count_enable && ps_tick; // RQ1
    // Bypass stands for the asynchronous counter, where the trigger reset is off
    assign trig_allowed = i_special_trigger && !(clock_source_select && sync_bypass); // RQ17
    // A live write or a trigger replaces the increment, so no flag then
    assign wrap         = inc && (count_reg == `TMC_COUNT_MAX) && !wr_low
                          && !(wr_high && !wide_access_mode)
                          && !trig_allowed; // RQ16

    // Writes win over trigger and increment
    assign count_next = wr_low ? {(wide_access_mode ? high_buf_reg : count_reg[15:8]), wdata} // RQ7
                      : (wr_high && !wide_access_mode) ? {wdata, count_reg[7:0]} // RQ8
                      : trig_allowed ? `TMC_COUNT_RST // RQ17
                      : inc ? count_reg + 16'h0001 // RQ16
                      : count_reg; // RQ1

    assign high_buf_next = (wr_high && wide_access_mode) ? wdata // RQ7
                         : (rd_low && wide_access_mode) ? count_reg[15:8] // RQ6
                         : high_buf_reg;

    // Set wins over the read clear
    assign overflow_flag_next = wrap || (overflow_flag_reg && !rd_stat); // RQ16

    // All count state freezes together with the clock enable
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_reg         <= `TMC_COUNT_RST;
            high_buf_reg      <= `TMC_BYTE_RST;
            overflow_flag_reg <= 1'b0;
        end else if (i_clk_en) begin
            count_reg         <= count_next;
            high_buf_reg      <= high_buf_next;
            overflow_flag_reg <= overflow_flag_next;
        end
    end

    // Level output: high until the status read or a mask clear
    assign o_irq = overflow_flag_reg && overflow_irq_enable; // RQ16
endmodule : tmc_timer
`default_nettype wire

// File: verification/tmc_partner.sv
// Model of the external count pin and the crystal oscillator output
`timescale 1ns/1ps
`default_nettype none
module tmc_partner (
    input  wire logic i_run,
    output logic      o_pin,
    output logic      o_xtal
);
    // Both clocks stand low between runs; edges sit 3 ns off the sampling edge
    always begin
        o_pin = 1'b0;
        wait (i_run);
        #3;
        while (i_run) begin
            o_pin = 1'b1;
            #30 o_pin = 1'b0;
            #30;
        end
    end
    always begin
        o_xtal = 1'b0;
        wait (i_run);
        #3;
        while (i_run) begin
            o_xtal = 1'b1;
            #50 o_xtal = 1'b0;
            #50;
        end
    end
endmodule : tmc_partner
`default_nettype wire

// File: verification/tmc_timer_chk.sv
// Port assertions for the timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"
module tmc_timer_chk
    import tmc_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic        i_clk_en,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [1:0]  i_port_direction_bits,
    input wire logic [1:0]  i_pin_levels,
    input wire logic [1:0]  o_pin_direction,
    input wire logic [1:0]  o_pin_read,
    input wire logic        o_crystal_osc_enable,
    input wire logic        o_irq
);
    logic       take, wr_reg, rd_reg, en_reg, osc_reg, msk_reg;
    logic [7:0] ad_reg;
    logic [1:0] lvl1_reg, lvl2_reg;
    // Pin levels reach the readback through two flops
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lvl1_reg <= 2'h0;
            lvl2_reg <= 2'h0;
        end else if (i_clk_en) begin
            lvl1_reg <= i_pin_levels;
            lvl2_reg <= lvl1_reg;
        end
    end
    assign take = i_hsel && i_htrans[1] && i_hready && i_clk_en;
    // Shadow of the enable, oscillator and mask bits, rebuilt from observed writes
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {wr_reg, rd_reg, en_reg, osc_reg, msk_reg} <= 5'h00;
            ad_reg <= 8'h00;
        end else if (i_clk_en && i_hready) begin
            wr_reg <= take && i_hwrite;
            rd_reg <= take && !i_hwrite;
            ad_reg <= i_haddr[7:0];
            if (wr_reg && ad_reg == `TMC_OFF_CTRL) begin
                en_reg  <= i_hwdata[`TMC_BIT_ENABLE];
                osc_reg <= i_hwdata[`TMC_BIT_OSCEN];
            end
            if (wr_reg && ad_reg == `TMC_OFF_MASK)
                msk_reg <= i_hwdata[`TMC_BIT_OVF];
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_rd_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    a_read_wait: assert property (take && !i_hwrite |=> s_rd_wait)
        else $error("read data phase not one wait cycle");
    a_write_ready: assert property (take && i_hwrite |=> o_hreadyout)
        else $error("write data phase stalled");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("response not okay");
    a_rdata_pad: assert property (rd_reg && o_hreadyout |-> o_hrdata[31:8] == `TMC_RD_PAD)
        else $error("read data upper bits not zero");
    a_pins_forced: assert property (en_reg |-> o_pin_direction == `TMC_PINS_INPUT
        && o_pin_read == `TMC_PINS_ZERO) else $error("clock pins not forced while enabled");
    a_pins_free: assert property (!en_reg |-> o_pin_direction == i_port_direction_bits
        && o_pin_read == lvl2_reg) else $error("clock pins not released while stopped");
    a_osc_follows: assert property (o_crystal_osc_enable == osc_reg)
        else $error("oscillator enable differs from written bit");
    a_irq_masked: assert property (!msk_reg |-> !o_irq)
        else $error("interrupt raised while masked");
endmodule : tmc_timer_chk
`default_nettype wire

// File: verification/tmc_timer_tb.sv
// Self-checking bench for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_tb
    import tmc_pkg::*;
;
    logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwr = 1'b0;
    logic        sys = 1'b0, trig = 1'b0, run = 1'b0;
    logic        hrdy, hresp, ext, xt, osc, irq;
    logic [1:0]  htr = 2'h0, dirb = 2'h0, lvl = 2'h0, pdir, pread;
    logic [31:0] ha = 32'h0, hwd = 32'h0, rd;
    logic [7:0]  q;
    int          mismatches = 0, cmp_count = 0, seed = 34, np = 0, nx = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        dirb <= 2'($random(seed));
        lvl  <= 2'($random(seed));
    end
    always @(posedge ext) np++;
    always @(posedge xt) nx++;
    tmc_partner prt_u (.i_run(run), .o_pin(ext), .o_xtal(xt));
    tmc_timer dut_u (
        .i_ref_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(ha),
        .i_htrans(htr), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy),
        .o_hrdata(rd), .o_hreadyout(hrdy), .o_hresp(hresp), .i_external_count_pin(ext),
        .i_crystal_osc_clk(xt), .i_sysclk_on_crystal(sys), .i_special_trigger(trig),
        .i_port_direction_bits(dirb), .i_pin_levels(lvl), .o_pin_direction(pdir),
        .o_pin_read(pread), .o_crystal_osc_enable(osc), .o_irq(irq));
    task chk(input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Each phase is held until hready is seen high at a falling edge, then to the next rising edge
    task bus(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        {hsel, htr, hwr, ha} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(negedge clk); while (hrdy !== 1'b1);
        @(posedge clk);
        {hsel, htr, hwd} <= {1'b0, 2'h0, 24'h0, d};
        do @(negedge clk); while (hrdy !== 1'b1);
        q = rd[7:0];
        @(posedge clk);
    endtask : bus
    task wr(input logic [7:0] a, d);
        bus(1'b1, a, d);
    endtask : wr
    task rc(input logic [7:0] a, e);
        bus(1'b0, a, 8'h00);
        chk({8'h00, q}, {8'h00, e});
    endtask : rc
    task results;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        #100000;
        mismatches++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) rc(8'(i * 4), 8'h00);
        wr(8'h00, 8'h40);
        rc(8'h00, 8'h00);
        sys <= 1'b1;
        repeat (4) @(posedge clk);
        rc(8'h00, 8'h40);
        sys <= 1'b0;
        $display("test status done");
        for (int p = 0; p < 4; p++) begin
            wr(8'h08, 8'h00);
            wr(8'h04, 8'h00);
            wr(8'h00, 8'(1 | (p << 4)));
            repeat ((32 << p) - 3) @(posedge clk);
            wr(8'h00, 8'h00);
            bus(1'b0, 8'h04, 8'h00);
            // Window is a whole number of divided ticks, so the count is exact
            chk({8'h00, q}, 16'h0008);
            repeat (20) @(posedge clk);
            rc(8'h04, q);
        end
        $display("test prescale done");
        wr(8'h00, 8'h80);
        wr(8'h08, 8'hAB);
        rc(8'h08, 8'hAB);
        wr(8'h04, 8'hCD);
        wr(8'h00, 8'h00);
        rc(8'h08, 8'hAB);
        wr(8'h00, 8'h80);
        wr(8'h08, 8'h12);
        wr(8'h00, 8'h00);
        rc(8'h08, 8'hAB);
        wr(8'h08, 8'h77);
        wr(8'h00, 8'h80);
        rc(8'h04, 8'hCD);
        rc(8'h08, 8'h77);
        $display("test wide done");
        wr(8'h00, 8'h00);
        wr(8'h08, 8'hFF);
        wr(8'h04, 8'hFE);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'h01);
        repeat (20) @(posedge clk);
        chk({15'h0, irq}, 16'h1);
        rc(8'h0C, 8'h01);
        rc(8'h0C, 8'h00);
        chk({15'h0, irq}, 16'h0);
        wr(8'h08, 8'h55);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        wr(8'h00, 8'h00);
        rc(8'h08, 8'h00);
        rc(8'h0C, 8'h00);
        $display("test overflow done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h08, 8'h00);
            wr(8'h04, 8'h00);
            // Crystal run at 1:8 only lands if the low write cleared the prescaler
            wr(8'h00, k ? 8'h3B : 8'h03);
            repeat (k * 50) @(posedge clk);
            np = 0;
            nx = 0;
            run <= 1'b1;
            repeat (300) @(posedge clk);
            run <= 1'b0;
            repeat (20) @(posedge clk);
            chk({14'h0, pdir}, 16'h3);
            chk({15'h0, osc}, 16'(k));
            wr(8'h00, 8'h00);
            bus(1'b0, 8'h04, 8'h00);
            chk({8'h00, q}, 16'(k ? nx / 8 : np));
        end
        $display("test external done");
        results();
    end
endmodule : tmc_timer_tb
bind tmc_timer tmc_timer_chk chk_u (.i_ref_clk, .i_nrst, .i_clk_en, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_port_direction_bits, .i_pin_levels, .o_pin_direction, .o_pin_read,
    .o_crystal_osc_enable, .o_irq);
`default_nettype wire
